// *** shared/hpb_pkg.sv ***
package hpb_pkg;
	// ---------------------------------------------------------------
	// Buffer layout
	// ---------------------------------------------------------------
	localparam int BUF_BYTES = 8;
	localparam logic [3:0] LEN_EMPTY = 4'h0;
	localparam logic [3:0] LEN_FULL = 4'h8;
	localparam logic [7:0] STATUS_CLEAR = 8'h00;
	localparam logic [7:0] FLAG_PATTERN = 8'h7E;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hF0B8;
	localparam logic [2:0] ONES_STUFF = 3'h5;
	localparam logic [2:0] ONES_FLAG = 3'h6;
	localparam logic [3:0] ONES_ABORT = 4'h7;
	localparam logic [3:0] ABORT_BITS = 4'h8;
	// ---------------------------------------------------------------
	// Error codes and system error bits
	// ---------------------------------------------------------------
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_CRC = 2'h1;
	localparam logic [1:0] ERR_ALIGN = 2'h2;
	localparam logic [1:0] ERR_ABORT = 2'h3;
	localparam logic [1:0] CLR_TX = 2'h1;
	localparam logic [1:0] CLR_RX = 2'h2;

	typedef struct packed {
		logic abort;
		logic end_frm;
		logic start_frm;
		logic [3:0] count;
	} hpb_tx_status_t;

	typedef struct packed {
		logic end_frm;
		logic start_frm;
		logic [1:0] err;
		logic [3:0] count;
	} hpb_rx_status_t;

	typedef struct packed {
		logic we;
		logic sel;
		logic [2:0] idx;
		logic [7:0] data;
	} hpb_wr_t;
endpackage

// *** src/hpb_crc.sv ***
`timescale 1ns/1ps
module hpb_crc (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Control
	input wire logic init,
	input wire logic en,
	input wire logic bit_in,
	// State
	output logic [15:0] crc
);
	logic fb;
	assign fb = crc[0] ^ bit_in;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crc <= hpb_pkg::CRC_PRESET;
		end else if (init) begin
			crc <= hpb_pkg::CRC_PRESET;
		end else if (en) begin
			crc <= (crc >> 1) ^ (fb ? hpb_pkg::CRC_POLY_REV : 16'h0000);
		end
	end
endmodule // hpb_crc

// *** src/hpb_rx_store.sv ***
`timescale 1ns/1ps
module hpb_rx_store (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Byte write
	input wire hpb_pkg::hpb_wr_t wr,
	// Readback
	input wire logic rd_sel,
	input wire logic [2:0] rd_idx,
	output logic [7:0] rd_data
);
	logic [7:0] mem_reg [0:15];

	// Per-entry storage
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_ent
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					mem_reg[g] <= 8'h00;
				end else if (wr.we && {wr.sel, wr.idx} == 4'(g)) begin
					mem_reg[g] <= wr.data;
				end
			end
		end
	endgenerate

	assign rd_data = mem_reg[{rd_sel, rd_idx}];
endmodule // hpb_rx_store

// *** src/hpb_port.sv ***
`timescale 1ns/1ps
// Functional notes
// - Idle status sends continuous flags in HDLC mode, continuous ones in sync mode
// - Frame start sends bytes with stuffing; CRC waits for frame end
// - Empty buffer inside frame sends abort
// - Frame end sends bytes, CRC, flag
// - Abort bit inside a frame sends eight ones
// - Start and end together: short frame
// - Underflow flagged, cleared by code 01
// - Carrier loss stops receive updates; sync mode first posts a part-filled buffer on a byte boundary
// - Buffers alternate starting at zero
// - Overflow flagged, cleared by code 02
// - Sync receive stores bits from bit zero
// - Sync status written on the edge the interrupt rises
// - Flags alone do nothing, shared zeros
// - Zero deletion, CRC, start bit six
// - Closing flag: CRC check, end bit
// - Error codes with priority
// - Idle abort reported once
// - Transmit status cleared on the edge the interrupt rises
// - Underflow sets error bit and interrupt
module hpb_port (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Mode
	input wire logic hdlc_mode,
	input wire logic rx_parallel_select,
	input wire logic carrier_detect_status,
	// Line bit timing
	input wire logic tx_bit_en,
	input wire logic rx_bit_en,
	input wire logic rx_line,
	output logic tx_line,
	// Host status writes
	input wire logic host_we,
	input wire logic [1:0] host_addr,
	input wire logic [7:0] host_wdata,
	// Transmit data buffer
	input wire logic [63:0] tx_data_buffer_0,
	input wire logic [63:0] tx_data_buffer_1,
	// Receive data buffer read
	input wire logic rx_rd_sel,
	input wire logic [2:0] rx_rd_idx,
	output logic [7:0] rx_rd_data,
	// Clear error command
	input wire logic clear_error_command,
	input wire logic [1:0] clear_error_code,
	// Status and interrupts
	output logic [7:0] tx_status_byte_0,
	output logic [7:0] tx_status_byte_1,
	output logic [7:0] rx_status_byte_0,
	output logic [7:0] rx_status_byte_1,
	output logic [1:0] system_error_byte,
	output logic tx_buffer_interrupt,
	output logic rx_buffer_interrupt,
	output logic error_interrupt
);
	// ---------------------------------------------------------------
	// Transmit state
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_DATA = 3'b001,
		TX_CRC = 3'b010,
		TX_FLAG = 3'b011,
		TX_ABORT = 3'b100
	} hpb_tx_state_t;

	hpb_tx_state_t tx_state_reg;
	logic tx_sel_reg;
	logic in_frame_reg;
	logic [5:0] tx_bitpos_reg;
	logic [3:0] tx_cnt_reg;
	logic [2:0] tx_ones_reg;
	logic [15:0] tx_crc_sh_reg;
	hpb_pkg::hpb_tx_status_t tx_cur;
	logic [63:0] tx_data_cur;
	logic tx_bit;
	logic stuff_now;
	logic tx_last_bit;
	logic [15:0] tx_crc;
	logic tx_crc_init;
	logic tx_crc_en;
	logic tx_done_pulse;
	logic underflow_pulse;

	assign tx_cur = tx_sel_reg ? tx_status_byte_1[6:0] : tx_status_byte_0[6:0];
	assign tx_data_cur = tx_sel_reg ? tx_data_buffer_1 : tx_data_buffer_0;
	assign tx_bit = tx_data_cur[tx_bitpos_reg];
	assign stuff_now = hdlc_mode && tx_ones_reg == hpb_pkg::ONES_STUFF;
	assign tx_last_bit = tx_bitpos_reg == {3'(tx_cur.count - 4'h1), 3'h7};
	assign tx_crc_init = tx_state_reg == TX_IDLE;
	assign tx_crc_en = tx_bit_en && tx_state_reg == TX_DATA && !stuff_now;

	hpb_crc u_tx_crc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.init(tx_crc_init),
		.en(tx_crc_en),
		.bit_in(tx_bit),
		.crc(tx_crc)
	);

	// ---------------------------------------------------------------
	// Transmit sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= TX_IDLE;
			in_frame_reg <= 1'b0;
			tx_bitpos_reg <= 6'h00;
			tx_cnt_reg <= 4'h0;
			tx_ones_reg <= 3'h0;
			tx_crc_sh_reg <= 16'h0000;
			tx_line <= 1'b1;
			tx_done_pulse <= 1'b0;
			underflow_pulse <= 1'b0;
		end else begin
			tx_done_pulse <= 1'b0;
			underflow_pulse <= 1'b0;
			// Idle decides between bits, after the buffer swap has settled
			if (tx_bit_en || (tx_state_reg == TX_IDLE && !tx_done_pulse)) begin
				case (tx_state_reg)
					TX_IDLE: begin
						// Ones run spans buffer joins inside a frame
						if (!in_frame_reg) begin
							tx_ones_reg <= 3'h0;
						end
						if (tx_cur.abort && in_frame_reg) begin
							tx_state_reg <= TX_ABORT;
							tx_cnt_reg <= 4'h0;
						end else if (tx_cur.count != hpb_pkg::LEN_EMPTY &&
							(!hdlc_mode || tx_cur.start_frm || in_frame_reg)) begin
							tx_state_reg <= TX_DATA;
							in_frame_reg <= hdlc_mode;
							tx_bitpos_reg <= 6'h00;
						end else if (in_frame_reg || (!hdlc_mode && tx_cur.count == 4'h0)) begin
							if (in_frame_reg) begin
								tx_state_reg <= TX_ABORT;
								tx_cnt_reg <= 4'h0;
							end
							underflow_pulse <= in_frame_reg;
							tx_line <= 1'b1;
						end else begin
							tx_state_reg <= TX_FLAG;
							tx_cnt_reg <= 4'h0;
						end
					end
					TX_DATA: begin
						if (stuff_now) begin
							tx_line <= 1'b0;
							tx_ones_reg <= 3'h0;
						end else begin
							tx_line <= tx_bit;
							tx_ones_reg <= tx_bit ? tx_ones_reg + 3'h1 : 3'h0;
							tx_bitpos_reg <= tx_bitpos_reg + 6'h01;
							if (tx_last_bit) begin
								tx_done_pulse <= 1'b1;
								if (hdlc_mode && tx_cur.end_frm) begin
									tx_state_reg <= TX_CRC;
									tx_crc_sh_reg <= ~(tx_crc_en ? ((tx_crc >> 1) ^
										((tx_crc[0] ^ tx_bit) ? hpb_pkg::CRC_POLY_REV :
										16'h0000)) : tx_crc);
									tx_cnt_reg <= 4'h0;
								end else begin
									tx_state_reg <= TX_IDLE;
								end
							end
						end
					end
					TX_CRC: begin
						if (stuff_now) begin
							tx_line <= 1'b0;
							tx_ones_reg <= 3'h0;
						end else begin
							tx_line <= tx_crc_sh_reg[0];
							tx_ones_reg <= tx_crc_sh_reg[0] ? tx_ones_reg + 3'h1 : 3'h0;
							tx_crc_sh_reg <= tx_crc_sh_reg >> 1;
							tx_cnt_reg <= tx_cnt_reg + 4'h1;
							if (tx_cnt_reg == 4'hF) begin
								tx_state_reg <= TX_FLAG;
								in_frame_reg <= 1'b0;
								tx_cnt_reg <= 4'h0;
							end
						end
					end
					TX_FLAG: begin
						if (stuff_now) begin
							// CRC ending in five ones still needs its zero
							tx_line <= 1'b0;
							tx_ones_reg <= 3'h0;
						end else begin
							tx_line <= hpb_pkg::FLAG_PATTERN[tx_cnt_reg[2:0]];
							tx_cnt_reg <= tx_cnt_reg + 4'h1;
							if (tx_cnt_reg == 4'h7) begin
								tx_state_reg <= TX_IDLE;
							end
						end
					end
					TX_ABORT: begin
						tx_line <= 1'b1;
						tx_cnt_reg <= tx_cnt_reg + 4'h1;
						if (tx_cnt_reg == hpb_pkg::ABORT_BITS - 4'h1) begin
							tx_state_reg <= TX_IDLE;
							in_frame_reg <= 1'b0;
							tx_done_pulse <= tx_cur.abort;
						end
					end
					default: tx_state_reg <= TX_IDLE;
				endcase
			end
		end
	end

	// Status cleared the same edge the interrupt rises; sel flips on that same edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_status_byte_0 <= 8'h00;
			tx_status_byte_1 <= 8'h00;
			tx_buffer_interrupt <= 1'b0;
		end else begin
			tx_buffer_interrupt <= tx_done_pulse;
			if (host_we && host_addr == 2'h0) begin
				tx_status_byte_0 <= host_wdata;
			end
			if (host_we && host_addr == 2'h1) begin
				tx_status_byte_1 <= host_wdata;
			end
			if (tx_done_pulse && !tx_sel_reg) begin
				tx_status_byte_0 <= hpb_pkg::STATUS_CLEAR;
			end
			if (tx_done_pulse && tx_sel_reg) begin
				tx_status_byte_1 <= hpb_pkg::STATUS_CLEAR;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_sel_reg <= 1'b0;
		end else if (underflow_pulse) begin
			tx_sel_reg <= 1'b0;
		end else if (tx_done_pulse) begin
			tx_sel_reg <= ~tx_sel_reg;
		end
	end

	// ---------------------------------------------------------------
	// Receive path
	// ---------------------------------------------------------------
	logic rx_sel_reg;
	logic rx_on_reg;
	logic [7:0] rx_shift_reg;
	logic [2:0] rx_bitcnt_reg;
	logic [3:0] rx_bytecnt_reg;
	logic [3:0] rx_ones_reg;
	logic [7:0] rx_win_reg;
	logic rx_frame_reg;
	logic rx_first_reg;
	logic rx_abort_seen_reg;
	logic [23:0] rx_hold_reg;
	logic [4:0] rx_hold_n_reg;
	hpb_pkg::hpb_wr_t rx_wr;
	logic rx_done_pulse;
	hpb_pkg::hpb_rx_status_t rx_stat_next;
	logic overflow_pulse;
	logic rx_cur_busy;
	logic [15:0] rx_crc;
	logic rx_crc_en;
	logic rx_crc_init;
	logic rx_active;
	logic is_flag;
	logic is_stuff;
	logic data_bit;

	assign rx_active = rx_on_reg && carrier_detect_status && rx_bit_en;
	assign rx_cur_busy = rx_sel_reg ? rx_status_byte_1 != 8'h00 : rx_status_byte_0 != 8'h00;
	assign is_flag = {rx_line, rx_win_reg[7:1]} == hpb_pkg::FLAG_PATTERN;
	assign is_stuff = !rx_line && rx_ones_reg == {1'b0, hpb_pkg::ONES_STUFF};
	assign data_bit = rx_hold_reg[0];
	// CRC eats bits seven back, so closing flag bits never reach it
	assign rx_crc_init = !rx_frame_reg || (rx_active && is_flag);
	assign rx_crc_en = rx_active && hdlc_mode && rx_frame_reg && !is_stuff &&
		rx_hold_n_reg >= 5'd7 && !is_flag;

	hpb_crc u_rx_crc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.init(rx_crc_init),
		.en(rx_crc_en),
		.bit_in(rx_hold_reg[16]),
		.crc(rx_crc)
	);

	hpb_rx_store u_store (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr(rx_wr),
		.rd_sel(rx_rd_sel),
		.rd_idx(rx_rd_idx),
		.rd_data(rx_rd_data)
	);

	// Receive enable: carrier loss drops it until host reselects
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_on_reg <= 1'b0;
		end else if (!carrier_detect_status) begin
			rx_on_reg <= 1'b0;
		end else if (overflow_pulse) begin
			rx_on_reg <= 1'b0;
		end else if (rx_parallel_select) begin
			rx_on_reg <= 1'b1;
		end
	end

	// Delay line holds 23 bits so CRC and flag never land in the buffer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_sel_reg <= 1'b0;
			rx_shift_reg <= 8'h00;
			rx_bitcnt_reg <= 3'h0;
			rx_bytecnt_reg <= 4'h0;
			rx_ones_reg <= 4'h0;
			rx_win_reg <= 8'h00;
			rx_frame_reg <= 1'b0;
			rx_first_reg <= 1'b1;
			rx_abort_seen_reg <= 1'b0;
			rx_hold_reg <= 24'h000000;
			rx_hold_n_reg <= 5'd0;
			rx_wr <= '0;
			rx_done_pulse <= 1'b0;
			rx_stat_next <= '0;
			overflow_pulse <= 1'b0;
		end else begin
			rx_wr.we <= 1'b0;
			rx_done_pulse <= 1'b0;
			overflow_pulse <= 1'b0;
			if (rx_on_reg && !carrier_detect_status && !hdlc_mode && rx_bitcnt_reg == 3'h0 &&
				rx_bytecnt_reg != 4'h0) begin
				rx_done_pulse <= 1'b1;
				rx_stat_next <= {4'h0, rx_bytecnt_reg};
				rx_bytecnt_reg <= 4'h0;
			end else if (!rx_on_reg) begin
				rx_sel_reg <= 1'b0;
				rx_bitcnt_reg <= 3'h0;
				rx_bytecnt_reg <= 4'h0;
				rx_frame_reg <= 1'b0;
				rx_first_reg <= 1'b1;
				rx_hold_n_reg <= 5'd0;
			end else if (rx_active && rx_cur_busy && (!hdlc_mode || (rx_frame_reg &&
				rx_hold_n_reg == 5'd23 && !is_flag && !is_stuff))) begin
				overflow_pulse <= 1'b1;
			end else if (rx_active && !hdlc_mode) begin
				rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
				rx_bitcnt_reg <= rx_bitcnt_reg + 3'h1;
				if (rx_bitcnt_reg == 3'h7) begin
					rx_wr <= '{we: 1'b1, sel: rx_sel_reg, idx: rx_bytecnt_reg[2:0],
						data: {rx_line, rx_shift_reg[7:1]}};
					rx_bytecnt_reg <= rx_bytecnt_reg + 4'h1;
					if (rx_bytecnt_reg == hpb_pkg::LEN_FULL - 4'h1) begin
						rx_done_pulse <= 1'b1;
						rx_stat_next <= {4'h0, hpb_pkg::LEN_FULL};
						rx_bytecnt_reg <= 4'h0;
					end
				end
			end else if (rx_active) begin
				rx_win_reg <= {rx_line, rx_win_reg[7:1]};
				rx_ones_reg <= rx_line ? ((rx_ones_reg == 4'hF) ? 4'hF : rx_ones_reg + 4'h1) :
					4'h0;
				if (!rx_line) begin
					rx_abort_seen_reg <= 1'b0;
				end
				if (rx_line && rx_ones_reg >= hpb_pkg::ONES_ABORT - 4'h1) begin
					if (rx_frame_reg || (!rx_abort_seen_reg && rx_ones_reg == hpb_pkg::ONES_ABORT)) begin
						rx_done_pulse <= 1'b1;
						rx_stat_next <= '{end_frm: 1'b1, start_frm: rx_first_reg,
							err: hpb_pkg::ERR_ABORT, count: rx_bytecnt_reg};
						rx_abort_seen_reg <= 1'b1;
						rx_frame_reg <= 1'b0;
						rx_bytecnt_reg <= 4'h0;
						rx_first_reg <= 1'b1;
					end
				end else if (is_flag) begin
					if (rx_frame_reg && (rx_bytecnt_reg != 4'h0 || !rx_first_reg)) begin
						rx_done_pulse <= 1'b1;
						rx_stat_next <= '{end_frm: 1'b1, start_frm: rx_first_reg,
							err: (rx_bitcnt_reg != 3'h0) ? hpb_pkg::ERR_ALIGN :
							(rx_crc != hpb_pkg::CRC_GOOD) ? hpb_pkg::ERR_CRC :
							hpb_pkg::ERR_NONE, count: rx_bytecnt_reg};
						rx_first_reg <= 1'b1;
						rx_bytecnt_reg <= 4'h0;
					end
					rx_frame_reg <= 1'b1;
					rx_hold_n_reg <= 5'd0;
					rx_bitcnt_reg <= 3'h0;
				end else if (!is_stuff && rx_frame_reg) begin
					rx_hold_reg[22] <= rx_line;
					rx_hold_reg[21:0] <= rx_hold_reg[22:1];
					if (rx_hold_n_reg != 5'd23) begin
						rx_hold_n_reg <= rx_hold_n_reg + 5'd1;
					end else begin
						rx_shift_reg <= {data_bit, rx_shift_reg[7:1]};
						rx_bitcnt_reg <= rx_bitcnt_reg + 3'h1;
						if (rx_bitcnt_reg == 3'h7) begin
							rx_wr <= '{we: 1'b1, sel: rx_sel_reg, idx: rx_bytecnt_reg[2:0],
								data: {data_bit, rx_shift_reg[7:1]}};
							rx_bytecnt_reg <= rx_bytecnt_reg + 4'h1;
							if (rx_bytecnt_reg == hpb_pkg::LEN_FULL - 4'h1) begin
								rx_done_pulse <= 1'b1;
								rx_stat_next <= '{end_frm: 1'b0, start_frm: rx_first_reg,
									err: hpb_pkg::ERR_NONE, count: hpb_pkg::LEN_FULL};
								rx_first_reg <= 1'b0;
								rx_bytecnt_reg <= 4'h0;
							end
						end
					end
				end
			end
			if (rx_done_pulse) begin
				rx_sel_reg <= ~rx_sel_reg;
			end
		end
	end

	// Status written the same edge the interrupt rises
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_status_byte_0 <= 8'h00;
			rx_status_byte_1 <= 8'h00;
			rx_buffer_interrupt <= 1'b0;
		end else begin
			rx_buffer_interrupt <= rx_done_pulse;
			if (host_we && host_addr == 2'h2) begin
				rx_status_byte_0 <= host_wdata;
			end
			if (host_we && host_addr == 2'h3) begin
				rx_status_byte_1 <= host_wdata;
			end
			if (rx_done_pulse && !rx_sel_reg) begin
				rx_status_byte_0 <= rx_stat_next;
			end
			if (rx_done_pulse && rx_sel_reg) begin
				rx_status_byte_1 <= rx_stat_next;
			end
		end
	end

	// ---------------------------------------------------------------
	// System error byte: set wins over clear
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			system_error_byte <= 2'b00;
			error_interrupt <= 1'b0;
		end else begin
			error_interrupt <= underflow_pulse || overflow_pulse;
			system_error_byte[0] <= underflow_pulse || (system_error_byte[0] &&
				!(clear_error_command && clear_error_code == hpb_pkg::CLR_TX));
			system_error_byte[1] <= overflow_pulse || (system_error_byte[1] &&
				!(clear_error_command && clear_error_code == hpb_pkg::CLR_RX));
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_tx_clear_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_buffer_interrupt |-> (tx_sel_reg ? tx_status_byte_0 : tx_status_byte_1) == 8'h00
		|| host_we) else $error("tx status not cleared");
	a_underflow_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
		underflow_pulse |=> system_error_byte[0] && error_interrupt)
		else $error("underflow not flagged");
	a_overflow_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
		overflow_pulse |=> system_error_byte[1] && error_interrupt)
		else $error("overflow not flagged");
	a_abort_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_state_reg == TX_ABORT && tx_bit_en |=> tx_line)
		else $error("abort not ones");
	a_rx_carrier: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!carrier_detect_status |=> !rx_wr.we)
		else $error("write after carrier loss");
	a_rx_irq_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_done_pulse |=> rx_buffer_interrupt && $past(rx_stat_next) != 8'h00)
		else $error("rx status not written");
	a_tx_sel_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_done_pulse && !underflow_pulse |=> tx_sel_reg != $past(tx_sel_reg))
		else $error("tx buffer index stuck");
	a_err_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clear_error_command && clear_error_code == hpb_pkg::CLR_TX && !underflow_pulse
		|=> !system_error_byte[0]) else $error("tx error not cleared");

	c_tx_frame_end: cover property (@(posedge clk_sys) tx_state_reg == TX_CRC);
	c_tx_abort: cover property (@(posedge clk_sys) tx_state_reg == TX_ABORT);
	c_rx_end: cover property (@(posedge clk_sys) rx_done_pulse && rx_stat_next.end_frm);
	c_overflow: cover property (@(posedge clk_sys) overflow_pulse);
endmodule // hpb_port

// *** dv/hpb_host_model.sv ***
`timescale 1ns/1ps
// --------------------------------
// Host side of the shared buffers
// --------------------------------
module hpb_host_model (
	// Clock
	input wire logic clk_sys,
	// Status writes
	output logic host_we,
	output logic [1:0] host_addr,
	output logic [7:0] host_wdata,
	// Data buffers and commands
	output logic [63:0] tx_data_buffer_0,
	output logic [63:0] tx_data_buffer_1,
	output logic rx_parallel_select,
	output logic clear_error_command,
	output logic [1:0] clear_error_code
);
	initial begin
		host_we = 1'b0;
		host_addr = 2'h0;
		host_wdata = 8'h00;
		tx_data_buffer_0 = 64'h0;
		tx_data_buffer_1 = 64'h0;
		rx_parallel_select = 1'b0;
		clear_error_command = 1'b0;
		clear_error_code = 2'h0;
	end
	// Released bus shows inverted data, never the stale value
	task automatic wr_stat(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		#1;
		host_addr = a;
		host_wdata = v;
		host_we = 1'b1;
		@(posedge clk_sys);
		#1;
		host_we = 1'b0;
		host_wdata = ~v;
	endtask
	// Data lands before its status byte
	task automatic send(input logic b, input logic [63:0] d, input logic [7:0] st);
		@(posedge clk_sys);
		#1;
		if (b) begin
			tx_data_buffer_1 = d;
		end else begin
			tx_data_buffer_0 = d;
		end
		wr_stat({1'b0, b}, st);
	endtask
	task automatic rx_init();
		wr_stat(2'h2, 8'h00);
		wr_stat(2'h3, 8'h00);
		@(posedge clk_sys);
		#1;
		rx_parallel_select = 1'b1;
		@(posedge clk_sys);
		#1;
		rx_parallel_select = 1'b0;
	endtask
	task automatic clr(input logic [1:0] c);
		@(posedge clk_sys);
		#1;
		clear_error_code = c;
		clear_error_command = 1'b1;
		@(posedge clk_sys);
		#1;
		clear_error_command = 1'b0;
	endtask
endmodule // hpb_host_model

// *** dv/test_hdlc_parallel_buffer_port.sv ***
`timescale 1ns/1ps
module test_hdlc_parallel_buffer_port;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic hdlc_mode = 1'b1;
	logic carrier_detect_status = 1'b1;
	logic tx_bit_en = 1'b0;
	logic rx_bit_en = 1'b0;
	logic rx_rd_sel = 1'b0;
	logic [2:0] rx_rd_idx = 3'h0;
	logic [1:0] ph = 2'h0;
	logic tx_line, rx_line, host_we, rx_parallel_select, clear_error_command;
	logic tx_buffer_interrupt, rx_buffer_interrupt, error_interrupt;
	logic [1:0] host_addr, clear_error_code, system_error_byte;
	logic [7:0] host_wdata, rx_rd_data, tx_status_byte_0, tx_status_byte_1;
	logic [7:0] rx_status_byte_0, rx_status_byte_1;
	logic [63:0] tx_data_buffer_0, tx_data_buffer_1;
	int err_total = 0;
	int n_checks = 0;
	int cnt [3] = '{0, 0, 0};
	int ones;
	// Loopback: our own receiver judges the framing we send
	assign rx_line = tx_line;
	hpb_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hdlc_mode(hdlc_mode),
		.rx_parallel_select(rx_parallel_select), .carrier_detect_status(carrier_detect_status),
		.tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_line(rx_line), .tx_line(tx_line),
		.host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
		.tx_data_buffer_0(tx_data_buffer_0), .tx_data_buffer_1(tx_data_buffer_1),
		.rx_rd_sel(rx_rd_sel), .rx_rd_idx(rx_rd_idx), .rx_rd_data(rx_rd_data),
		.clear_error_command(clear_error_command), .clear_error_code(clear_error_code),
		.tx_status_byte_0(tx_status_byte_0), .tx_status_byte_1(tx_status_byte_1),
		.rx_status_byte_0(rx_status_byte_0), .rx_status_byte_1(rx_status_byte_1),
		.system_error_byte(system_error_byte), .tx_buffer_interrupt(tx_buffer_interrupt),
		.rx_buffer_interrupt(rx_buffer_interrupt), .error_interrupt(error_interrupt));
	hpb_host_model host (.clk_sys(clk_sys), .host_we(host_we), .host_addr(host_addr),
		.host_wdata(host_wdata), .tx_data_buffer_0(tx_data_buffer_0),
		.tx_data_buffer_1(tx_data_buffer_1), .rx_parallel_select(rx_parallel_select),
		.clear_error_command(clear_error_command), .clear_error_code(clear_error_code));
	always #20 clk_sys = ~clk_sys;
	// Four cycles per line bit; receive samples mid-bit
	always @(posedge clk_sys) begin
		#1;
		ph = ph + 2'h1;
		tx_bit_en = (ph == 2'h0);
		rx_bit_en = (ph == 2'h2);
	end
	always @(posedge clk_sys) begin
		if (tx_buffer_interrupt === 1'b1) cnt[0]++;
		if (rx_buffer_interrupt === 1'b1) cnt[1]++;
		if (error_interrupt === 1'b1) cnt[2]++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_cnt(input int k, input int n);
		for (int i = 0; i < 3000 && cnt[k] < n; i++) @(posedge clk_sys);
		#2;
		chk(8'(cnt[k] >= n), 8'h01);
	endtask
	task automatic rd(input logic s, input logic [2:0] i, input logic [7:0] e);
		rx_rd_sel = s;
		rx_rd_idx = i;
		#1;
		chk(rx_rd_data, e);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_total++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		chk({7'h0, tx_line}, 8'h01);
		chk(tx_status_byte_0 | rx_status_byte_1, 8'h00);
		#1;
		rst_n = 1'b1;
		host.rx_init();
		ones = 0;
		repeat (64) @(posedge clk_sys) if (rx_bit_en) ones += int'(tx_line);
		chk(8'(ones), 8'd12);
		chk(8'(cnt[1]), 8'h00);
		host.send(1'b0, 64'h0000_0000_00C3_B2A1, 8'h33);
		wait_cnt(0, 1);
		chk(tx_status_byte_0, 8'h00);
		wait_cnt(1, 1);
		chk(rx_status_byte_0, 8'hC3);
		rd(1'b0, 3'h0, 8'hA1);
		rd(1'b0, 3'h1, 8'hB2);
		rd(1'b0, 3'h2, 8'hC3);
		host.send(1'b1, 64'h5A, 8'h31);
		wait_cnt(0, 2);
		chk(tx_status_byte_1, 8'h00);
		wait_cnt(1, 2);
		chk(rx_status_byte_1, 8'hC1);
		rd(1'b1, 3'h0, 8'h5A);
		// Both receive buffers still full: next frame must overflow
		host.send(1'b0, 64'h77, 8'h31);
		wait_cnt(2, 1);
		chk({6'h0, system_error_byte}, 8'h02);
		chk(rx_status_byte_0, 8'hC3);
		host.clr(2'h2);
		chk({6'h0, system_error_byte}, 8'h00);
		host.rx_init();
		host.send(1'b1, 64'hBEEF, 8'h12);
		wait_cnt(2, 2);
		chk({6'h0, system_error_byte}, 8'h01);
		wait_cnt(1, 3);
		chk((rx_status_byte_0 | rx_status_byte_1) & 8'hB0, 8'hB0);
		host.clr(2'h1);
		chk({6'h0, system_error_byte}, 8'h00);
		host.rx_init();
		carrier_detect_status = 1'b0;
		ones = cnt[1];
		host.send(1'b0, 64'h99, 8'h31);
		wait_cnt(0, cnt[0] + 1);
		repeat (300) @(posedge clk_sys);
		chk(rx_status_byte_0 | rx_status_byte_1, 8'h00);
		chk(8'(cnt[1] - ones), 8'h00);
		stop_test();
	end
endmodule // test_hdlc_parallel_buffer_port
